// >>> include/ppc_pkg.sv
// types for the port configuration block
package ppc_pkg;
  typedef enum logic [2:0] {
    PPC_RX_IDLE     = 3'b001,
    PPC_RX_PREAMBLE = 3'b010,
    PPC_RX_DATA     = 3'b100
  } ppc_rx_state_t;
endpackage

// >>> include/ppc_regs.svh
// register offset, bit positions, reset values for the port configuration bits
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
`define PPC_PORT_CONFIGURATION_ADDR  5'h10
`define PPC_BIT_LOOPBACK_DISABLE     8
`define PPC_BIT_CRS_EXTEND           7
`define PPC_BIT_RSVD6                6
`define PPC_BIT_PREAMBLE_PASS        5
`define PPC_BIT_RSVD4                4
`define PPC_BIT_RSVD3                3
`define PPC_BIT_RSVD2                2
`define PPC_BIT_ALT_NEXT_PAGE        1
`define PPC_CFG_RESET                16'h0080
`define PPC_CFG_WRITE_MASK           16'h01fe
`define PPC_PREAMBLE_NIBBLE          4'h5
`define PPC_SFD_NIBBLE               4'hd
`endif

// >>> src/ppc_cfg_reg.sv
// one stored configuration bit with write strobe and reset value
`timescale 1ns/10ps
module ppc_cfg_reg #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_we,
  input  wire logic i_wd,
  output logic      o_q
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_q <= RESET_VAL;
    end else if (i_we) begin
      o_q <= i_wd;
    end
  end
endmodule

// >>> src/ppc_port_config.sv
// port configuration bits 8..1 and the receive-side behaviour they steer
// Function
// - bit 8 set stops half-duplex 10BASE-T loopback
// - bit 7 set holds CRS until RX_DV drops, at 10 Mbps only
// - preamble pass clear: RX_DV with SFD
// - preamble pass set: RX_DV with CRS, preamble
// - 100 Mbps always passes preamble
// - bit 1 enables alternate next-page capability
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_port_config (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_we,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  input  wire logic        i_speed_100,
  input  wire logic        i_full_duplex,
  input  wire logic        i_tx_en,
  input  wire logic [3:0]  i_txd,
  input  wire logic        i_line_crs,
  input  wire logic        i_line_rx_valid,
  input  wire logic [3:0]  i_line_rxd,
  output logic             o_crs,
  output logic             o_rx_dv,
  output logic      [3:0]  o_rxd,
  output logic             o_alternate_next_page_enable
);
  // address decode and masked write data
  wire        sel        = (i_reg_addr == `PPC_PORT_CONFIGURATION_ADDR);
  wire        we         = sel & i_reg_we;
  wire [15:0] wmask_data = i_reg_wdata & `PPC_CFG_WRITE_MASK;
  logic [15:0] cfg;

  // one stored flip-flop per implemented bit
  // bit 1: alternate next page
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_ALT_NEXT_PAGE))) u_bit1 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_ALT_NEXT_PAGE]),
    .o_q   (cfg[`PPC_BIT_ALT_NEXT_PAGE])
  );

  // bit 2: reserved, stored
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_RSVD2))) u_bit2 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_RSVD2]),
    .o_q   (cfg[`PPC_BIT_RSVD2])
  );

  // bit 3: reserved, stored
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_RSVD3))) u_bit3 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_RSVD3]),
    .o_q   (cfg[`PPC_BIT_RSVD3])
  );

  // bit 4: reserved, stored
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_RSVD4))) u_bit4 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_RSVD4]),
    .o_q   (cfg[`PPC_BIT_RSVD4])
  );

  // bit 5: preamble pass
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_PREAMBLE_PASS))) u_bit5 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_PREAMBLE_PASS]),
    .o_q   (cfg[`PPC_BIT_PREAMBLE_PASS])
  );

  // bit 6: reserved, stored
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_RSVD6))) u_bit6 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_RSVD6]),
    .o_q   (cfg[`PPC_BIT_RSVD6])
  );

  // bit 7: carrier sense extend, resets set
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_CRS_EXTEND))) u_bit7 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_CRS_EXTEND]),
    .o_q   (cfg[`PPC_BIT_CRS_EXTEND])
  );

  // bit 8: loopback disable
  ppc_cfg_reg #(.RESET_VAL(1'(`PPC_CFG_RESET >> `PPC_BIT_LOOPBACK_DISABLE))) u_bit8 (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_we  (we),
    .i_wd  (wmask_data[`PPC_BIT_LOOPBACK_DISABLE]),
    .o_q   (cfg[`PPC_BIT_LOOPBACK_DISABLE])
  );

  // bits 15..9 and 0 are not implemented
  assign cfg[0]     = 1'b0;
  assign cfg[15:9]  = 7'h00;

  // named control bits
  wire twisted_pair_loopback_disable = cfg[`PPC_BIT_LOOPBACK_DISABLE];
  wire carrier_sense_extend_select   = cfg[`PPC_BIT_CRS_EXTEND];
  wire preamble_pass                 = cfg[`PPC_BIT_PREAMBLE_PASS];
  wire alternate_next_page_enable    = cfg[`PPC_BIT_ALT_NEXT_PAGE];

  // reserved bits store what is written and are left to software
  assign o_reg_rdata = sel ? cfg : 16'h0000;
  assign o_alternate_next_page_enable = alternate_next_page_enable;

  // half-duplex 10BASE-T loops transmit back unless disabled
  wire       loop_on    = ~i_speed_100
                        & ~i_full_duplex
                        & ~twisted_pair_loopback_disable;
  wire       loop_tx    = loop_on & i_tx_en;
  wire       crs_src    = loop_on ? (i_tx_en | i_line_crs)
                                  : i_line_crs;
  wire       src_valid  = loop_tx | i_line_rx_valid;
  wire [3:0] src_data   = loop_tx ? i_txd : i_line_rxd;
  // preamble is always passed at 100 Mbps
  wire       pass_pre   = preamble_pass | i_speed_100;
  // frame delimiter seen on the selected source
  wire       sfd_seen   = src_valid & (src_data == `PPC_SFD_NIBBLE);
  // carrier extension only applies at 10 Mbps
  wire       crs_ext_on = carrier_sense_extend_select & ~i_speed_100;

  ppc_pkg::ppc_rx_state_t st_q, st_d;
  logic       dv_q, dv_d;
  logic       crs_q, crs_d;
  logic [3:0] rxd_q, rxd_d;

  // next receive state and outputs
  always_comb begin
    st_d  = st_q;
    dv_d  = 1'b0;
    rxd_d = 4'h0;
    unique case (st_q)
      ppc_pkg::PPC_RX_IDLE: begin
        if (crs_src && pass_pre) begin
          st_d  = ppc_pkg::PPC_RX_PREAMBLE;
          dv_d  = 1'b1;
          rxd_d = `PPC_PREAMBLE_NIBBLE;
        end else if (crs_src) begin
          st_d = ppc_pkg::PPC_RX_PREAMBLE;
        end
      end
      ppc_pkg::PPC_RX_PREAMBLE: begin
        if (!crs_src) begin
          st_d = ppc_pkg::PPC_RX_IDLE;
        end else if (sfd_seen) begin
          st_d  = ppc_pkg::PPC_RX_DATA;
          dv_d  = 1'b1;
          rxd_d = src_data;
        end else if (pass_pre) begin
          dv_d  = 1'b1;
          rxd_d = `PPC_PREAMBLE_NIBBLE;
        end
      end
      ppc_pkg::PPC_RX_DATA: begin
        if (src_valid) begin
          dv_d  = 1'b1;
          rxd_d = src_data;
        end else begin
          st_d = ppc_pkg::PPC_RX_IDLE;
        end
      end
      default: st_d = ppc_pkg::PPC_RX_IDLE;
    endcase
    // extended carrier sense lasts until receive data valid drops
    crs_d = crs_src | (crs_ext_on & dv_d);
  end

  // receive state and output registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= ppc_pkg::PPC_RX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dv_q <= 1'b0;
    end else begin
      dv_q <= dv_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      crs_q <= 1'b0;
    end else begin
      crs_q <= crs_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rxd_q <= 4'h0;
    end else begin
      rxd_q <= rxd_d;
    end
  end

  // registered MII receive outputs
  assign o_rx_dv = dv_q;
  assign o_crs   = crs_q;
  assign o_rxd   = rxd_q;
endmodule

// >>> test/ppc_line_src.sv
// line side: preamble, delimiter, data; valid outlasts carrier by one nibble
`timescale 1ns/10ps
module ppc_line_src (
  input  logic       i_clk,
  input  logic       i_go,
  output logic       o_crs,
  output logic       o_valid,
  output logic [3:0] o_rxd
);
  logic [3:0] n_q = 4'h0;
  always_ff @(posedge i_clk) n_q <= i_go ? 4'h1 : n_q == 4'h0 ? n_q : n_q + 4'h1;
  assign o_crs = n_q != 4'h0 && n_q < 4'hd;
  assign o_valid = n_q != 4'h0 && n_q < 4'he;
  assign o_rxd = !o_valid ? ~n_q : n_q < 4'h8 ? 4'h5 : n_q == 4'h8 ? 4'hd : n_q;
endmodule

// >>> test/ppc_port_config_sva.sv
// port configuration checker
`timescale 1ns/10ps
module ppc_port_config_sva (
  input logic i_clk, i_rst, i_reg_we, i_speed_100, i_full_duplex, i_tx_en, i_line_crs,
  input logic i_line_rx_valid, o_crs, o_rx_dv, o_alternate_next_page_enable,
  input logic [4:0] i_reg_addr,
  input logic [15:0] i_reg_wdata, o_reg_rdata,
  input logic [3:0] o_rxd
);
  logic [15:0] cfg_q;
  wire wr = i_reg_we && i_reg_addr == 5'h10;
  wire ten = !i_speed_100 && !i_tx_en;
  always_ff @(posedge i_clk) cfg_q <= i_rst ? 16'h0080 : wr ? i_reg_wdata & 16'h01fe : cfg_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_read_back: assert property (wr |=> i_reg_addr != 5'h10 || o_reg_rdata == cfg_q)
    else $error("readback");
  a_alt_np: assert property (wr |=> o_alternate_next_page_enable == $past(i_reg_wdata[1]))
    else $error("alt np");
  a_pass_pre: assert property ($rose(i_line_crs) && ten && cfg_q[5] |=> o_rx_dv && o_rxd == 4'h5)
    else $error("pass");
  a_fast_pre: assert property ($rose(i_line_crs) && i_speed_100 && !i_tx_en |=> o_rx_dv)
    else $error("fast");
  a_sfd_start: assert property ($rose(o_rx_dv) && !$past(i_speed_100) && !$past(i_tx_en)
    && !cfg_q[5] |-> o_rxd == 4'hd) else $error("sfd");
  a_crs_ext: assert property (cfg_q[7] && !i_speed_100 && o_rx_dv |-> o_crs)
    else $error("crs");
  a_loop_off: assert property ((cfg_q[8] && !i_speed_100 && !i_full_duplex && i_tx_en
    && !i_line_crs && !i_line_rx_valid)[*2] |=> !o_rx_dv) else $error("loop");
  c_pre: cover property (o_rx_dv && o_rxd == 4'h5);
  c_sfd: cover property ($rose(o_rx_dv) && o_rxd == 4'hd);
  c_wr: cover property (wr);
  c_crs_ext: cover property (o_crs && o_rx_dv && !i_line_crs);
endmodule

// >>> test/test_ppc_port_config.sv
// bench for the port configuration block
`timescale 1ns/10ps
module test_ppc_port_config;
  logic i_clk = 0, i_rst = 1, i_reg_we = 0, i_speed_100 = 0, i_full_duplex = 1, i_tx_en = 0;
  logic go = 0, dv_q = 0, i_line_crs, i_line_rx_valid, o_crs, o_rx_dv;
  logic o_alternate_next_page_enable;
  logic [4:0] i_reg_addr = 5'h10;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic [3:0] i_txd = 4'h0, i_line_rxd, o_rxd, exp_q[$];
  logic [31:0] seed = 32'h8630_612f;
  int n_errors = 0, checks_done = 0, cyc = 0;
  ppc_port_config uut (.*);
  ppc_line_src line (.i_clk, .i_go(go), .o_crs(i_line_crs), .o_valid(i_line_rx_valid),
    .o_rxd(i_line_rxd));
  initial forever #25 i_clk = ~i_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [15:0] d);
    @(posedge i_clk) begin i_reg_we <= 1; i_reg_wdata <= d; end
    @(posedge i_clk) i_reg_we <= 0;
  endtask
  task frame(input logic spd, pass);
    wr(pass ? 16'h00a0 : 16'h0080);
    exp_q.push_back(spd || pass ? 4'h5 : 4'hd);
    @(posedge i_clk) begin i_speed_100 <= spd; go <= 1; end
    @(posedge i_clk) go <= 0;
    repeat (20) @(posedge i_clk);
  endtask
  always @(negedge i_clk) begin
    dv_q <= o_rx_dv;
    if (o_rx_dv && !dv_q) begin
      chk(o_rxd, exp_q.pop_front());
      chk(o_crs, 1'b1);
    end
    cyc <= cyc + 1;
    if (cyc == 2000) begin n_errors++; print_verdict; end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    #1 chk(o_reg_rdata, 16'h0080);
    repeat (4) begin
      seed = xs(seed);
      wr(seed[15:0] & 16'h01a2);
      #1 chk(o_reg_rdata, seed[15:0] & 16'h01a2);
      chk(o_alternate_next_page_enable, seed[1]);
    end
    @(posedge i_clk) i_reg_addr <= 5'h11;
    #1 chk(o_reg_rdata, 16'h0000);
    @(posedge i_clk) i_reg_addr <= 5'h10;
    for (int k = 0; k < 4; k++) frame(k[1], k[0]);
    wr(16'h00a0);
    exp_q.push_back(4'h5);
    @(posedge i_clk) begin i_speed_100 <= 0; i_full_duplex <= 0; i_tx_en <= 1; end
    repeat (6) @(posedge i_clk);
    i_tx_en <= 0;
    repeat (4) @(posedge i_clk);
    wr(16'h0180);
    @(posedge i_clk) begin i_speed_100 <= 0; i_full_duplex <= 0; i_tx_en <= 1; end
    repeat (6) @(posedge i_clk);
    i_tx_en <= 0;
    repeat (4) @(posedge i_clk);
    if (exp_q.size() != 0) n_errors++;
    print_verdict;
  end
endmodule
bind ppc_port_config ppc_port_config_sva chk_i (.*);
